//--- src/serial_cfg_defines.svh
// Bit addresses, field positions and counts of the serial controller.
`ifndef SERIAL_CFG_DEFINES_SVH
`define SERIAL_CFG_DEFINES_SVH

// ----------------------------------------------------------------
// Bit addresses on the bit-serial I/O bus
// ----------------------------------------------------------------
`define ADDR_RESET 5'h1f
`define ADDR_FORCE_BREAK 5'h11
`define ADDR_REQUEST_SEND 5'h10
`define ADDR_SEL_FORMAT 5'h0e
`define ADDR_SEL_INTERVAL 5'h0d
`define ADDR_SEL_RX_RATE 5'h0c
`define ADDR_SEL_TX_RATE 5'h0b
`define ADDR_RATE_TOP 5'h0a
`define ADDR_BYTE_TOP 5'h07

// ----------------------------------------------------------------
// Format register fields
// ----------------------------------------------------------------
`define FMT_STOP_HI 7
`define FMT_STOP_LO 6
`define FMT_PARITY_ENABLE 5
`define FMT_PARITY_ODD 4
`define FMT_DIVIDE_BY_FOUR 3
`define FMT_LEN_HI 1
`define FMT_LEN_LO 0

// ----------------------------------------------------------------
// Rate register fields
// ----------------------------------------------------------------
`define RATE_PRESCALE_BIT 10
`define RATE_DIVISOR_TOP 9

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define DIV_THREE_LAST 2'h2
`define DIV_FOUR_LAST 2'h3
`define PRESCALE_LAST 3'h7
`define TIMER_PRESCALE_LAST 6'h3f
`define LEN_BASE 4'h5
`define RX_SHIFT_WIDTH 4'ha
`define STOP_HALVES_ONE 5'h02
`define STOP_HALVES_ONE_HALF 5'h03
`define STOP_HALVES_TWO 5'h04
`define FRAME_IDLE 12'hfff

`endif

//--- src/serial_cfg_pkg.sv
// Types shared by the serial controller.
package serial_cfg_pkg;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_type;

  typedef struct packed {
    logic [2:0] pre;
    logic [9:0] cnt;
    logic tick;
  } rate_gen_type;

endpackage : serial_cfg_pkg

//--- src/async_serial_config_regs.sv
// Serial controller configuration registers, rate generators, timer, transmitter and receiver.
`timescale 1ns/10ps
`include "serial_cfg_defines.svh"

// ----------------------------------------------------------------
// Receive character FIFO
// ----------------------------------------------------------------
module rx_char_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("FIFO needs a depth of at least two and a width of at least one.");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_type;

  fifo_state_type s_q;
  fifo_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (in_valid && s_q.in_ready) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      s_d.count = s_d.count + 1'b1;
    end
    if (out_ready && s_q.out_valid) begin
      s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      s_d.count = s_d.count - 1'b1;
    end
    s_d.in_ready = (s_d.count != CW'(DEPTH));
    s_d.out_valid = (s_d.count != '0);
    s_d.out_data = s_d.mem[s_d.rd];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{in_ready: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.in_ready;
  assign out_valid = s_q.out_valid;
  assign out_data = s_q.out_data;
endmodule : rx_char_fifo

// ----------------------------------------------------------------
// Controller top
// ----------------------------------------------------------------
// Contract
// - Stop bits 00=1.5, 01=2, else one.
// - Receiver checks exactly one stop bit.
// - Bits 5,4 choose none, even, odd parity.
// - Parity bit added after configured data bits.
// - Parity counts data and parity, not stops.
// - Input clock divided by four or three.
// - Divided clock drives timer and rate generators.
// - Length bits give five to eight bits.
// - Interval register loads when interval selected and format not.
// - Timer period is internal period*64*value.
// - Receive prescale divides by eight or one.
// - Ten-bit receive divisor from 1 to 1023.
// - Divider ticks at twice the bit rate.
// - Receive rate loads under its select flag.
// - Transmit rate uses the same two stages.
// - Transmit rate loads under its select flag.
// - Holding buffer loads when unselected, no break.
// - Buffer moves to shift register when empty and send requested.
// - Upper buffer bits ignored; bit 7 clears empty.
// - Top bit write clears that select flag.
// - Select priority format, interval, rates, buffer.
// - Reset bit write sets all select flags.
module async_serial_config_regs
  import serial_cfg_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_write,
  input wire logic [4:0] bus_addr,
  input wire logic bus_bit,
  input wire logic rin,
  output logic xout,
  output logic request_send_n,
  output logic tx_buffer_empty,
  output logic tx_shift_empty,
  output logic select_flags_set,
  output logic timer_elapsed,
  output logic rx_overrun,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_parity_error,
  output logic rx_framing_error
);

  typedef struct packed {
    logic format_reg_select;
    logic interval_reg_select;
    logic rx_rate_select;
    logic tx_rate_select;
    logic force_break;
    logic request_send_on;
    logic [7:0] char_format_control;
    logic [7:0] timer_interval;
    logic [10:0] receive_rate_divider;
    logic [10:0] transmit_rate_divider;
    logic [7:0] transmit_holding_buffer;
    logic tx_buffer_empty;
    logic [1:0] div_cnt;
    logic tint;
    logic [5:0] tm_pre;
    logic [7:0] tm_cnt;
    logic tm_evt;
    rate_gen_type rx_gen;
    rate_gen_type tx_gen;
    logic [11:0] tx_shift_reg;
    logic [4:0] tx_halves;
    logic tx_phase;
    logic tx_busy;
    logic xout;
    logic request_send_n;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic rx_lvl;
    rx_state_type rx_st;
    logic rx_phase;
    logic [3:0] rx_cnt;
    logic [9:0] rx_sr;
    logic rx_overrun;
    logic push_valid;
    logic [9:0] push_data;
    logic flags_set;
  } ctrl_state_type;

  localparam ctrl_state_type RESET_STATE = '{
    format_reg_select: 1'b1, interval_reg_select: 1'b1, rx_rate_select: 1'b1, tx_rate_select: 1'b1,
    tx_buffer_empty: 1'b1, xout: 1'b1, request_send_n: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1, rx_s3: 1'b1,
    rx_lvl: 1'b1, flags_set: 1'b1, rx_st: RX_IDLE, default: '0};

  ctrl_state_type s_q;
  ctrl_state_type s_d;
  logic fifo_in_ready;

  if (FIFO_DEPTH < 2) begin : g_check
    $error("Receive FIFO depth must be at least two.");
  end

  // Two-stage rate generator: optional divide by eight, then the ten-bit divisor.
  function automatic rate_gen_type rate_step(input rate_gen_type g, input logic [10:0] rate, input logic tint);
    rate_gen_type r;
    r = g;
    r.tick = 1'b0;
    if (tint) begin
      if (rate[`RATE_PRESCALE_BIT] && g.pre != `PRESCALE_LAST) begin
        r.pre = g.pre + 1'b1;
      end else begin
        r.pre = '0;
        if (g.cnt <= 10'h001) begin
          r.cnt = rate[`RATE_DIVISOR_TOP:0];
          r.tick = 1'b1;
        end else begin
          r.cnt = g.cnt - 1'b1;
        end
      end
    end
    return r;
  endfunction : rate_step

  // Builds the outgoing frame: start bit, data, parity, then idle ones.
  function automatic logic [11:0] build_frame(input logic [7:0] data, input logic [7:0] fmt);
    logic [11:0] f;
    logic [3:0] len;
    logic par;
    f = `FRAME_IDLE;
    len = `LEN_BASE + {2'b00, fmt[`FMT_LEN_HI:`FMT_LEN_LO]};
    par = fmt[`FMT_PARITY_ODD];
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < len) begin
        f[i + 1] = data[i];
        par = par ^ data[i];
      end
    end
    if (fmt[`FMT_PARITY_ENABLE]) begin
      f[len + 4'h1] = par;
    end
    return f;
  endfunction : build_frame

  always_comb begin
    logic [3:0] len;
    logic par_en;
    logic [3:0] nbits;
    logic [4:0] stop_halves;
    logic [9:0] aligned;
    logic [7:0] data;
    logic par_bit;
    s_d = s_q;
    len = `LEN_BASE + {2'b00, s_q.char_format_control[`FMT_LEN_HI:`FMT_LEN_LO]};
    par_en = s_q.char_format_control[`FMT_PARITY_ENABLE];
    nbits = len + {3'b000, par_en};
    aligned = '0;
    data = '0;
    par_bit = 1'b0;
    case (s_q.char_format_control[`FMT_STOP_HI:`FMT_STOP_LO])
      2'b00: stop_halves = `STOP_HALVES_ONE_HALF;
      2'b01: stop_halves = `STOP_HALVES_TWO;
      default: stop_halves = `STOP_HALVES_ONE;
    endcase

    // ----------------------------------------------------------------
    // Internal clock and interval timer
    // ----------------------------------------------------------------
    s_d.tint = 1'b0;
    if (s_q.div_cnt >= (s_q.char_format_control[`FMT_DIVIDE_BY_FOUR] ? `DIV_FOUR_LAST : `DIV_THREE_LAST)) begin
      s_d.div_cnt = '0;
      s_d.tint = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 1'b1;
    end
    s_d.tm_evt = 1'b0;
    if (s_q.tint) begin
      if (s_q.tm_pre == `TIMER_PRESCALE_LAST) begin
        s_d.tm_pre = '0;
        if (s_q.tm_cnt <= 8'h01) begin
          s_d.tm_cnt = s_q.timer_interval;
          s_d.tm_evt = 1'b1;
        end else begin
          s_d.tm_cnt = s_q.tm_cnt - 1'b1;
        end
      end else begin
        s_d.tm_pre = s_q.tm_pre + 1'b1;
      end
    end
    s_d.rx_gen = rate_step(s_q.rx_gen, s_q.receive_rate_divider, s_q.tint);
    s_d.tx_gen = rate_step(s_q.tx_gen, s_q.transmit_rate_divider, s_q.tint);

    // ----------------------------------------------------------------
    // Bit writes
    // ----------------------------------------------------------------
    if (bus_write) begin
      if (bus_addr == `ADDR_RESET) begin
        s_d.format_reg_select = 1'b1;
        s_d.interval_reg_select = 1'b1;
        s_d.rx_rate_select = 1'b1;
        s_d.tx_rate_select = 1'b1;
        s_d.force_break = 1'b0;
        s_d.request_send_on = 1'b0;
        s_d.tx_buffer_empty = 1'b1;
        s_d.tx_busy = 1'b0;
        s_d.tx_shift_reg = `FRAME_IDLE;
      end else if (bus_addr == `ADDR_FORCE_BREAK) begin
        s_d.force_break = bus_bit;
      end else if (bus_addr == `ADDR_REQUEST_SEND) begin
        s_d.request_send_on = bus_bit;
      end else if (bus_addr == `ADDR_SEL_FORMAT) begin
        s_d.format_reg_select = bus_bit;
      end else if (bus_addr == `ADDR_SEL_INTERVAL) begin
        s_d.interval_reg_select = bus_bit;
      end else if (bus_addr == `ADDR_SEL_RX_RATE) begin
        s_d.rx_rate_select = bus_bit;
      end else if (bus_addr == `ADDR_SEL_TX_RATE) begin
        s_d.tx_rate_select = bus_bit;
      end else if (bus_addr <= `ADDR_RATE_TOP) begin
        if (s_q.format_reg_select) begin
          if (bus_addr <= `ADDR_BYTE_TOP) begin
            s_d.char_format_control[bus_addr[2:0]] = bus_bit;
          end
          if (bus_addr == `ADDR_BYTE_TOP) begin
            s_d.format_reg_select = 1'b0;
          end
        end else if (s_q.interval_reg_select) begin
          if (bus_addr <= `ADDR_BYTE_TOP) begin
            s_d.timer_interval[bus_addr[2:0]] = bus_bit;
          end
          if (bus_addr == `ADDR_BYTE_TOP) begin
            s_d.interval_reg_select = 1'b0;
          end
        end else if (s_q.rx_rate_select || s_q.tx_rate_select) begin
          if (s_q.rx_rate_select) begin
            s_d.receive_rate_divider[bus_addr[3:0]] = bus_bit;
          end
          if (s_q.tx_rate_select) begin
            s_d.transmit_rate_divider[bus_addr[3:0]] = bus_bit;
          end
          if (bus_addr == `ADDR_RATE_TOP) begin
            s_d.rx_rate_select = 1'b0;
            s_d.tx_rate_select = 1'b0;
          end
        end else if (!s_q.force_break) begin
          if (bus_addr <= `ADDR_BYTE_TOP) begin
            s_d.transmit_holding_buffer[bus_addr[2:0]] = bus_bit;
          end
          if (bus_addr == `ADDR_BYTE_TOP) begin
            s_d.tx_buffer_empty = 1'b0;
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    if (s_q.tx_busy && s_q.tx_gen.tick) begin
      s_d.tx_phase = ~s_q.tx_phase;
      s_d.tx_halves = s_q.tx_halves - 1'b1;
      if (s_q.tx_phase) begin
        s_d.tx_shift_reg = {1'b1, s_q.tx_shift_reg[11:1]};
      end
      if (s_q.tx_halves == 5'h01) begin
        s_d.tx_busy = 1'b0;
      end
    end else if (!s_q.tx_busy && !s_q.tx_buffer_empty && s_q.request_send_on && bus_addr != `ADDR_RESET) begin
      s_d.tx_shift_reg = build_frame(s_q.transmit_holding_buffer, s_q.char_format_control);
      s_d.tx_halves = 5'({nbits, 1'b0}) + 5'h02 + stop_halves;
      s_d.tx_phase = 1'b0;
      s_d.tx_busy = 1'b1;
      s_d.tx_buffer_empty = 1'b1;
    end
    if (s_d.tx_busy) begin
      s_d.xout = s_d.tx_shift_reg[0];
    end else begin
      s_d.xout = !(s_d.force_break && s_d.request_send_on && s_d.tx_buffer_empty);
    end
    s_d.request_send_n = !(s_d.request_send_on || s_d.tx_busy || !s_d.tx_buffer_empty || s_d.force_break);

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    s_d.rx_s1 = rin;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.rx_s3 = s_q.rx_s2;
    if (s_q.rx_s2 == s_q.rx_s3) begin
      s_d.rx_lvl = s_q.rx_s3;
    end
    s_d.push_valid = 1'b0;
    case (s_q.rx_st)
      RX_IDLE: begin
        // Only a falling edge starts a frame, so a line still low after a framing error is not taken for a start.
        if (s_q.rx_lvl && !s_d.rx_lvl) begin
          s_d.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (s_q.rx_gen.tick) begin
          s_d.rx_st = s_q.rx_lvl ? RX_IDLE : RX_DATA;
          s_d.rx_phase = 1'b0;
          s_d.rx_cnt = '0;
        end
      end
      RX_DATA: begin
        if (s_q.rx_gen.tick) begin
          s_d.rx_phase = ~s_q.rx_phase;
          if (s_q.rx_phase) begin
            s_d.rx_sr = {s_q.rx_lvl, s_q.rx_sr[9:1]};
            s_d.rx_cnt = s_q.rx_cnt + 1'b1;
            if (s_d.rx_cnt == nbits) begin
              s_d.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (s_q.rx_gen.tick) begin
          s_d.rx_phase = ~s_q.rx_phase;
          if (s_q.rx_phase) begin
            aligned = s_q.rx_sr >> (`RX_SHIFT_WIDTH - nbits);
            for (int i = 0; i < 8; i++) begin
              data[i] = aligned[i] && (4'(i) < len);
            end
            par_bit = aligned[len];
            s_d.push_data = {!s_q.rx_lvl,
                             par_en && ((^data ^ par_bit) != s_q.char_format_control[`FMT_PARITY_ODD]),
                             data};
            s_d.push_valid = fifo_in_ready;
            s_d.rx_overrun = !fifo_in_ready;
            s_d.rx_st = RX_IDLE;
          end
        end
      end
      default: s_d.rx_st = RX_IDLE;
    endcase
    s_d.flags_set = s_d.format_reg_select || s_d.interval_reg_select || s_d.rx_rate_select ||
                    s_d.tx_rate_select || s_d.force_break;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  rx_char_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(s_q.push_valid),
    .in_ready(fifo_in_ready),
    .in_data(s_q.push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data({rx_framing_error, rx_parity_error, rx_data})
  );

  assign xout = s_q.xout;
  assign request_send_n = s_q.request_send_n;
  assign tx_buffer_empty = s_q.tx_buffer_empty;
  assign tx_shift_empty = !s_q.tx_busy;
  assign select_flags_set = s_q.flags_set;
  assign timer_elapsed = s_q.tm_evt;
  assign rx_overrun = s_q.rx_overrun;
endmodule : async_serial_config_regs

//--- sim/async_serial_config_regs_props.sv
// Port-level assertions for the serial controller.
`timescale 1ns/10ps
module serial_cfg_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_write,
  input wire logic [4:0] bus_addr,
  input wire logic bus_bit,
  input wire logic rin,
  input wire logic xout,
  input wire logic request_send_n,
  input wire logic tx_buffer_empty,
  input wire logic tx_shift_empty,
  input wire logic select_flags_set,
  input wire logic timer_elapsed,
  input wire logic rx_overrun,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity_error,
  input wire logic rx_framing_error
);
  logic rst_wr_q;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Remembers a reset-bit write so that its buffer flush is not taken for a transfer.
  always_ff @(posedge clk) begin
    rst_wr_q <= bus_write && bus_addr == 5'h1f;
  end
  sequence s_reset_write;
    bus_write && bus_addr == 5'h1f;
  endsequence
  sequence s_load;
    $rose(tx_buffer_empty) && !rst_wr_q;
  endsequence
  property p_reset_state;
    disable iff (1'b0) !nrst |=> select_flags_set && tx_buffer_empty && tx_shift_empty && xout
      && !rx_valid && !timer_elapsed;
  endproperty
  property p_reset_bit;
    s_reset_write |=> select_flags_set && tx_buffer_empty && tx_shift_empty;
  endproperty
  property p_buf_fill;
    bus_write && bus_addr == 5'h07 && tx_buffer_empty && !select_flags_set |=> !tx_buffer_empty;
  endproperty
  property p_buf_guard;
    select_flags_set && tx_buffer_empty |=> tx_buffer_empty;
  endproperty
  property p_load_start;
    s_load |-> !tx_shift_empty && !xout;
  endproperty
  property p_idle_mark;
    tx_shift_empty && !select_flags_set |-> xout;
  endproperty
  property p_rts;
    !tx_buffer_empty || !tx_shift_empty |-> !request_send_n;
  endproperty
  property p_timer_pulse;
    timer_elapsed |=> !timer_elapsed [*8];
  endproperty
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_parity_error)
      && $stable(rx_framing_error);
  endproperty
  property p_fmt_select;
    bus_write && bus_addr == 5'h0e && bus_bit |=> select_flags_set;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  a_reset_bit: assert property (p_reset_bit) else $error("reset bit write ignored");
  a_buf_fill: assert property (p_buf_fill) else $error("buffer still empty");
  a_buf_guard: assert property (p_buf_guard) else $error("buffer loaded while selected");
  a_load_start: assert property (p_load_start) else $error("no start bit after load");
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not high");
  a_rts: assert property (p_rts) else $error("send request off while busy");
  a_timer_pulse: assert property (p_timer_pulse) else $error("timer pulses too close");
  a_rx_hold: assert property (p_rx_hold) else $error("rx head changed unpopped");
  a_fmt_select: assert property (p_fmt_select) else $error("format select lost");
endmodule : serial_cfg_props

bind async_serial_config_regs serial_cfg_props u_serial_cfg_props (.clk, .nrst, .bus_write, .bus_addr,
  .bus_bit, .rin, .xout, .request_send_n, .tx_buffer_empty, .tx_shift_empty, .select_flags_set,
  .timer_elapsed, .rx_overrun, .rx_valid, .rx_ready, .rx_data, .rx_parity_error, .rx_framing_error);

//--- sim/serial_terminal.sv
// Far-side terminal model: decodes the transmit line and sends frames on the receive line.
`timescale 1ns/10ps
module serial_terminal (
  input wire logic clk,
  input wire logic xout,
  output logic rin
);
  int h = 3;
  int len = 5;
  bit pen = 1'b0;
  bit parity_odd_select = 1'b0;
  logic [7:0] got = 8'h00;
  logic got_par = 1'b0;
  initial rin = 1'b1;
  // Samples each bit two cycles past its start, counted from the start edge.
  initial begin
    forever begin
      @(negedge xout);
      repeat (2 * h + 2) @(posedge clk);
      #1;
      got = 8'h00;
      for (int k = 0; k < len + pen; k++) begin
        if (k < len) got[k] = xout;
        else got_par = xout;
        repeat (2 * h) @(posedge clk);
        #1;
      end
    end
  end
  task automatic send(input logic [7:0] d, input bit perr, input bit ferr);
    logic [10:0] fr;
    fr = {2'b11, d, 1'b0};
    fr[len + 1] = ^(d & (8'hff >> (8 - len))) ^ parity_odd_select ^ perr;
    fr[len + 1 + pen] = !ferr;
    @(posedge clk);
    for (int k = 0; k < len + pen + 2; k++) begin
      rin <= fr[k];
      repeat (2 * h) @(posedge clk);
    end
    rin <= 1'b1;
    repeat (2 * h) @(posedge clk);
  endtask : send
endmodule : serial_terminal

//--- sim/async_serial_config_regs_test.sv
// Self-checking bench for the serial controller registers and data paths.
`timescale 1ns/10ps
`include "serial_cfg_defines.svh"
module async_serial_config_regs_test import serial_cfg_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic bus_write = 1'b0;
  logic [4:0] bus_addr = 5'h00;
  logic bus_bit = 1'b0;
  logic rx_ready = 1'b0;
  logic rin, xout, request_send_n, tx_buffer_empty, tx_shift_empty, select_flags_set;
  logic timer_elapsed, rx_overrun, rx_valid, rx_parity_error, rx_framing_error, px;
  logic [7:0] rx_data, fmt, d, msk;
  logic [7:0] q [5];
  logic [10:0] rate;
  int err_total = 0;
  int tests_run = 0;
  int seed = 32'h0d9aa1f2;
  int hh, len, dv, iv, n, run;
  bit pen, parity_odd_select;

  async_serial_config_regs #(.FIFO_DEPTH(4)) u_async_serial_config_regs (.clk, .nrst, .bus_write,
    .bus_addr, .bus_bit, .rin, .xout, .request_send_n, .tx_buffer_empty, .tx_shift_empty,
    .select_flags_set, .timer_elapsed, .rx_overrun, .rx_valid, .rx_ready, .rx_data,
    .rx_parity_error, .rx_framing_error);
  serial_terminal u_serial_terminal (.clk, .xout, .rin);

  initial forever #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus, wait and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic chk_win(input int got, input int lo, input int hi, input string m);
    tests_run++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %0t %s got %0d exp %0d..%0d", $time, m, got, lo, hi);
    end
  endtask : chk_win
  task automatic wr(input logic [4:0] a, input logic b);
    @(posedge clk);
    bus_write <= 1'b1;
    bus_addr <= a;
    bus_bit <= b;
  endtask : wr
  task automatic idle();
    @(posedge clk);
    bus_write <= 1'b0;
    #1;
  endtask : idle
  task automatic wbits(input logic [10:0] v, input int cnt);
    for (int i = 0; i < cnt; i++) wr(5'(i), v[i]);
  endtask : wbits
  task automatic wait_for(ref logic s, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (s !== v && cnt < 20000);
  endtask : wait_for
  task automatic pop(input logic [7:0] e, input logic pe, input logic fe);
    if (rx_valid !== 1'b1) wait_for(rx_valid, 1'b1, n);
    chk(rx_data, e, "rx data");
    chk(rx_parity_error, pe, "rx parity flag");
    chk(rx_framing_error, fe, "rx framing flag");
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    @(posedge clk);
    #1;
  endtask : pop
  function automatic logic par_bit(input logic [7:0] v);
    return ^(v & msk) ^ parity_odd_select;
  endfunction : par_bit
  // Trailing marks of the frame plus the stop time, in cycles.
  function automatic int exp_run(input logic [7:0] v);
    logic [8:0] b;
    int k;
    b = {1'b0, v & msk};
    b[len] = pen ? par_bit(v) : 1'b0;
    k = 0;
    for (int i = len + pen - 1; i >= 0 && b[i]; i--) k++;
    return 2 * k * hh + (fmt[7] ? 2 : fmt[6] ? 4 : 3) * hh;
  endfunction : exp_run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    idle();
    chk(select_flags_set, 1'b1, "flags after reset");
    chk(tx_buffer_empty, 1'b1, "buffer after reset");
    for (int t = 0; t < 6; t++) begin
      fmt = 8'($random(seed)) & 8'hfb;
      if (t == 0) fmt = 8'h3b;
      if (t == 1) fmt = 8'h40;
      len = 5 + fmt[1:0];
      pen = fmt[5];
      parity_odd_select = fmt[4];
      msk = 8'hff >> (8 - len);
      dv = fmt[3] ? 4 : 3;
      rate = {(t == 2), 10'(4 + {$random(seed)} % 3)};
      hh = dv * (rate[10] ? 8 : 1) * int'(rate[9:0]);
      iv = 1 + {$random(seed)} % 3;
      u_serial_terminal.h = hh;
      u_serial_terminal.len = len;
      u_serial_terminal.pen = pen;
      u_serial_terminal.parity_odd_select = parity_odd_select;
      wr(`ADDR_RESET, 1'b0);
      wbits({3'b000, fmt}, 8);
      wbits(11'(iv), 8);
      wbits(rate, 11);
      idle();
      chk(select_flags_set, 1'b0, "selects not cleared");
      wr(`ADDR_REQUEST_SEND, 1'b1);
      d = 8'($random(seed));
      wbits({3'b000, d}, 8);
      idle();
      chk(tx_buffer_empty, 1'b0, "buffer not loaded");
      wait_for(tx_shift_empty, 1'b0, n);
      run = 0;
      while (tx_shift_empty !== 1'b1 && run < 9000) begin
        px = xout;
        @(posedge clk);
        #1;
        run = (!px && xout) ? 1 : run + 1;
      end
      chk_win(run, exp_run(d), exp_run(d) + 2, "stop length");
      repeat (4) @(posedge clk);
      chk(u_serial_terminal.got, d & msk, "tx data");
      if (pen) chk(u_serial_terminal.got_par, par_bit(d), "tx parity");
      d = 8'($random(seed));
      u_serial_terminal.send(d, t == 0, t == 2);
      pop(d & msk, t == 0, t == 2);
      repeat (3) wait_for(timer_elapsed, 1'b1, n);
      chk_win(n, dv * 64 * iv, dv * 64 * iv, "timer period");
      $display("test %0d done", t);
    end
    for (int j = 0; j < 5; j++) begin
      q[j] = 8'($random(seed));
      u_serial_terminal.send(q[j], 1'b0, 1'b0);
    end
    chk(rx_overrun, 1'b1, "no overrun");
    for (int j = 0; j < 4; j++) pop(q[j] & msk, 1'b0, 1'b0);
    chk(rx_valid, 1'b0, "fifo not drained");
    $display("test fifo done");
    wr(5'h14, 1'b1);
    idle();
    chk(select_flags_set, 1'b0, "unmapped write");
    wr(`ADDR_FORCE_BREAK, 1'b1);
    wbits(11'h0a5, 8);
    idle();
    repeat (2) @(posedge clk);
    #1;
    chk(tx_buffer_empty, 1'b1, "buffer loaded in break");
    chk(xout, 1'b0, "break not driven");
    $display("test break done");
    give_verdict();
  end
endmodule : async_serial_config_regs_test
